// file: verilog/hspc_pkg.sv
// constants and register map of the high speed up/down counter block
package hspc_pkg;
    // counter geometry
    localparam int NUM_CH = 4;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 8;
    // per channel register window: channel index in addr[6:5], register in addr[4:2]
    localparam int CH_SEL_LSB = 5;
    localparam int REG_SEL_LSB = 2;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_START = 3'h1;
    localparam logic [2:0] REG_UPPER = 3'h2;
    localparam logic [2:0] REG_LOWER = 3'h3;
    localparam logic [2:0] REG_ACTUAL = 3'h4;
    localparam logic [2:0] REG_FLAGS = 3'h5;
    // global registers, addr[7] set
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
    localparam int GLOBAL_BIT = 7;
    // control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_RELEASE = 1;
    localparam int CTRL_DOWN = 2;
    localparam int CTRL_PRESET = 3;
    localparam int CTRL_CLEAR = 4;
    localparam int CTRL_W = 5;
    // flags register fields
    localparam int FLAG_UPPER = 0;
    localparam int FLAG_LOWER = 1;
    localparam int FLAG_ZERO = 2;
    // interrupt layout: three events per channel, channel n at bits 3n+2..3n
    localparam int EV_PER_CH = 3;
    localparam int EV_CARRY = 0;
    localparam int EV_UPPER = 1;
    localparam int EV_LOWER = 2;
    localparam int IRQ_W = NUM_CH * EV_PER_CH;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// file: verilog/hspc_ch_if.sv
// link between the register file and one counter channel
`timescale 1ns/10ps
interface hspc_ch_if #(parameter int WIDTH = 32);
    logic enable;
    logic releaseByEnable;
    logic countDown;
    logic presetLoad;
    logic countClear;
    logic [WIDTH-1:0] startValue;
    logic [WIDTH-1:0] upperThreshold;
    logic [WIDTH-1:0] lowerThreshold;
    logic [WIDTH-1:0] actualValue;
    logic upperFlag;
    logic lowerFlag;
    logic zeroFlag;
    logic rangeCarry;

    modport ctrl (
        output enable, releaseByEnable, countDown, presetLoad, countClear,
        output startValue, upperThreshold, lowerThreshold,
        input actualValue, upperFlag, lowerFlag, zeroFlag, rangeCarry
    );
    modport chan (
        input enable, releaseByEnable, countDown, presetLoad, countClear,
        input startValue, upperThreshold, lowerThreshold,
        output actualValue, upperFlag, lowerFlag, zeroFlag, rangeCarry
    );
endinterface

// file: verilog/hspc_channel.sv
// one fast pulse counter channel with thresholds and range carry
`timescale 1ns/10ps
module hspc_channel #(
    parameter int WIDTH = 32
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic counterInput, // pulse input of this channel
    hspc_ch_if.chan cfg // control in, results out
);
    typedef struct packed {
        logic prevIn;
        logic prevPreset;
        logic [WIDTH-1:0] actual;
        logic upper;
        logic lower;
        logic zero;
        logic carry;
    } hspc_chst_t;

    hspc_chst_t s_q, s_d;
    logic active;
    logic pulse;
    logic [WIDTH:0] stepped;
    logic outOfRange;

    initial
    begin
        if (WIDTH < 2)
            $error("hspc_channel: WIDTH must be at least 2");
    end

    // next state: clear beats preset, preset beats counting
    always_comb
    begin
        s_d = s_q;
        s_d.prevIn = counterInput;
        s_d.prevPreset = cfg.presetLoad;
        s_d.carry = 1'b0;
        active = cfg.enable | ~cfg.releaseByEnable;
        pulse = counterInput & ~s_q.prevIn;
        // sign-extended step so both range ends are seen
        if (cfg.countDown)
            stepped = {s_q.actual[WIDTH-1], s_q.actual} - {{WIDTH{1'b0}}, 1'b1};
        else
            stepped = {s_q.actual[WIDTH-1], s_q.actual} + {{WIDTH{1'b0}}, 1'b1};
        outOfRange = stepped[WIDTH] != stepped[WIDTH-1];
        if (cfg.countClear)
            s_d.actual = '0;
        else if (cfg.presetLoad & ~s_q.prevPreset)
            s_d.actual = cfg.startValue;
        else if (pulse & active)
        begin
            if (outOfRange)
                s_d.carry = 1'b1;
            else
                s_d.actual = stepped[WIDTH-1:0];
        end
        // flags follow the value they are registered with
        s_d.upper = $signed(s_d.actual) >= $signed(cfg.upperThreshold);
        s_d.lower = $signed(s_d.actual) <= $signed(cfg.lowerThreshold);
        s_d.zero = s_d.actual == '0;
    end

    // single state register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cfg.actualValue = s_q.actual;
    assign cfg.upperFlag = s_q.upper;
    assign cfg.lowerFlag = s_q.lower;
    assign cfg.zeroFlag = s_q.zero;
    assign cfg.rangeCarry = s_q.carry;

    AST_CARRY_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_n)
        s_q.carry |=> !s_q.carry || $past(pulse))
        else $error("carry held without a new edge");
    AST_CLEAR_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg.countClear |=> s_q.actual == '0)
        else $error("clear did not zero the count");
    AST_HOLD_ON_RANGE: assert property (@(posedge mclk) disable iff (!rst_n)
        s_q.carry |-> s_q.actual == $past(s_q.actual))
        else $error("value moved on out-of-range step");
    // first edge after release still shows the reset flags, so it is skipped
    AST_UPPER_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n) |->
        s_q.upper == ($signed(s_q.actual) >= $signed($past(cfg.upperThreshold))))
        else $error("upper flag wrong");
    AST_LOWER_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n) |->
        s_q.lower == ($signed(s_q.actual) <= $signed($past(cfg.lowerThreshold))))
        else $error("lower flag wrong");
    AST_PRESET: assert property (@(posedge mclk) disable iff (!rst_n)
        (!cfg.countClear && cfg.presetLoad && !s_q.prevPreset)
        |=> s_q.actual == $past(cfg.startValue))
        else $error("preset not loaded");
    AST_GATED: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg.releaseByEnable && !cfg.enable && !cfg.countClear && !cfg.presetLoad)
        |=> $stable(s_q.actual))
        else $error("count moved while gated off");
    AST_UP_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
        (pulse && active && !cfg.countDown && !outOfRange && !cfg.countClear
        && !(cfg.presetLoad && !s_q.prevPreset)) |=> s_q.actual == $past(s_q.actual) + 1'b1)
        else $error("up count step wrong");
    COV_CARRY: cover property (@(posedge mclk) disable iff (!rst_n) s_q.carry);
    COV_DOWN: cover property (@(posedge mclk) disable iff (!rst_n)
        pulse && active && cfg.countDown);
    COV_PRESET: cover property (@(posedge mclk) disable iff (!rst_n)
        cfg.presetLoad && !s_q.prevPreset);
endmodule

// file: verilog/hspc_top.sv
// four fast pulse counters with an APB register file and interrupt
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module hspc_top #(
    parameter int NUM_CH = hspc_pkg::NUM_CH,
    parameter int WIDTH = hspc_pkg::CNT_W
) (
    input wire logic mclk, // 250 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [NUM_CH-1:0] counterInput, // pulse inputs, one per counter
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [hspc_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [NUM_CH-1:0] upperFlag, // per counter upper flag
    output logic [NUM_CH-1:0] lowerFlag, // per counter lower flag
    output logic [NUM_CH-1:0] rangeCarry, // per counter carry pulse
    output logic irq // level interrupt
);
    localparam int IRQ_W = NUM_CH * hspc_pkg::EV_PER_CH;

    typedef struct packed {
        logic [NUM_CH-1:0][hspc_pkg::CTRL_W-1:0] ctrl;
        logic [NUM_CH-1:0][WIDTH-1:0] startVal;
        logic [NUM_CH-1:0][WIDTH-1:0] upperThr;
        logic [NUM_CH-1:0][WIDTH-1:0] lowerThr;
        logic [NUM_CH-1:0] upperPrev;
        logic [NUM_CH-1:0] lowerPrev;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } hspc_regs_t;

    hspc_regs_t s_q, s_d;
    logic [NUM_CH-1:0][WIDTH-1:0] actualArr;
    logic [NUM_CH-1:0] zeroArr;
    logic setup;
    logic access;
    logic [IRQ_W-1:0] events;

    initial
    begin
        if (NUM_CH < 1 || NUM_CH > 4)
            $error("hspc_top: NUM_CH must be 1 to 4");
        if (WIDTH < 2 || WIDTH > 32)
            $error("hspc_top: WIDTH must be 2 to 32");
    end

    // channel number field of an address
    function automatic int chOf(input logic [hspc_pkg::ADDR_W-1:0] a);
        return int'(a[6:hspc_pkg::CH_SEL_LSB]);
    endfunction

    // register field of an address
    function automatic logic [2:0] regOf(input logic [hspc_pkg::ADDR_W-1:0] a);
        return a[4:hspc_pkg::REG_SEL_LSB];
    endfunction

    // counter instances, input n wired only to counter n
    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_ch
            hspc_ch_if #(.WIDTH(WIDTH)) chIf ();
            assign chIf.enable = s_q.ctrl[i][hspc_pkg::CTRL_ENABLE];
            assign chIf.releaseByEnable = s_q.ctrl[i][hspc_pkg::CTRL_RELEASE];
            assign chIf.countDown = s_q.ctrl[i][hspc_pkg::CTRL_DOWN];
            assign chIf.presetLoad = s_q.ctrl[i][hspc_pkg::CTRL_PRESET];
            assign chIf.countClear = s_q.ctrl[i][hspc_pkg::CTRL_CLEAR];
            assign chIf.startValue = s_q.startVal[i];
            assign chIf.upperThreshold = s_q.upperThr[i];
            assign chIf.lowerThreshold = s_q.lowerThr[i];
            assign actualArr[i] = chIf.actualValue;
            assign upperFlag[i] = chIf.upperFlag;
            assign lowerFlag[i] = chIf.lowerFlag;
            assign zeroArr[i] = chIf.zeroFlag;
            assign rangeCarry[i] = chIf.rangeCarry;
            hspc_channel #(.WIDTH(WIDTH)) u_ch (
                .mclk(mclk),
                .rst_n(rst_n),
                .counterInput(counterInput[i]),
                .cfg(chIf)
            );
        end
    endgenerate

    // event vector: carry pulse and rising flags per channel
    always_comb
    begin
        events = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            events[i*hspc_pkg::EV_PER_CH + hspc_pkg::EV_CARRY] = rangeCarry[i];
            events[i*hspc_pkg::EV_PER_CH + hspc_pkg::EV_UPPER] =
                upperFlag[i] & ~s_q.upperPrev[i];
            events[i*hspc_pkg::EV_PER_CH + hspc_pkg::EV_LOWER] =
                lowerFlag[i] & ~s_q.lowerPrev[i];
        end
    end

    // bus slave and register file; answer is given in the first access cycle
    always_comb
    begin
        s_d = s_q;
        s_d.ready = 1'b0;
        s_d.slverr = 1'b0;
        s_d.upperPrev = upperFlag;
        s_d.lowerPrev = lowerFlag;
        setup = psel & ~penable;
        access = psel & penable & s_q.ready;
        // read data is latched at setup so prdata comes from a flop
        if (setup)
        begin
            s_d.ready = 1'b1;
            s_d.rdata = hspc_pkg::WORD_RST;
            if (paddr[hspc_pkg::GLOBAL_BIT])
            begin
                if (paddr == hspc_pkg::OFF_IRQ_STATUS)
                    s_d.rdata[IRQ_W-1:0] = s_q.irqStat;
                else if (paddr == hspc_pkg::OFF_IRQ_MASK)
                    s_d.rdata[IRQ_W-1:0] = s_q.irqMask;
                else
                    s_d.slverr = 1'b1;
            end
            else if (chOf(paddr) >= NUM_CH)
                s_d.slverr = 1'b1;
            else
            begin
                unique case (regOf(paddr))
                    hspc_pkg::REG_CTRL:
                        s_d.rdata[hspc_pkg::CTRL_W-1:0] = s_q.ctrl[chOf(paddr)];
                    hspc_pkg::REG_START:
                        s_d.rdata[WIDTH-1:0] = s_q.startVal[chOf(paddr)];
                    hspc_pkg::REG_UPPER:
                        s_d.rdata[WIDTH-1:0] = s_q.upperThr[chOf(paddr)];
                    hspc_pkg::REG_LOWER:
                        s_d.rdata[WIDTH-1:0] = s_q.lowerThr[chOf(paddr)];
                    hspc_pkg::REG_ACTUAL:
                        s_d.rdata[WIDTH-1:0] = actualArr[chOf(paddr)];
                    hspc_pkg::REG_FLAGS:
                    begin
                        s_d.rdata[hspc_pkg::FLAG_UPPER] = upperFlag[chOf(paddr)];
                        s_d.rdata[hspc_pkg::FLAG_LOWER] = lowerFlag[chOf(paddr)];
                        s_d.rdata[hspc_pkg::FLAG_ZERO] = zeroArr[chOf(paddr)];
                    end
                    default:
                        s_d.slverr = 1'b1;
                endcase
            end
        end
        else
        begin
            s_d.slverr = 1'b0;
        end
        // writes land at the access edge; a bad address writes nothing
        if (access && pwrite && !s_q.slverr)
        begin
            if (paddr == hspc_pkg::OFF_IRQ_MASK)
                s_d.irqMask = pwdata[IRQ_W-1:0];
            else if (!paddr[hspc_pkg::GLOBAL_BIT])
            begin
                unique case (regOf(paddr))
                    hspc_pkg::REG_CTRL:
                        s_d.ctrl[chOf(paddr)] = pwdata[hspc_pkg::CTRL_W-1:0];
                    hspc_pkg::REG_START:
                        s_d.startVal[chOf(paddr)] = pwdata[WIDTH-1:0];
                    hspc_pkg::REG_UPPER:
                        s_d.upperThr[chOf(paddr)] = pwdata[WIDTH-1:0];
                    hspc_pkg::REG_LOWER:
                        s_d.lowerThr[chOf(paddr)] = pwdata[WIDTH-1:0];
                    default:
                        s_d.irqMask = s_d.irqMask; // read-only registers
                endcase
            end
        end
        // read clears only what it reported; events after the snapshot stay pending
        if (access && !pwrite && paddr == hspc_pkg::OFF_IRQ_STATUS)
            s_d.irqStat = s_q.irqStat & ~s_q.rdata[IRQ_W-1:0];
        s_d.irqStat = s_d.irqStat | events;
        s_d.irq = |(s_d.irqStat & s_d.irqMask);
    end

    // single state register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr; // only ever set together with ready
    assign irq = s_q.irq;

    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
        irq == |(s_q.irqStat & s_q.irqMask))
        else $error("interrupt level mismatch");
    AST_CARRY_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
        rangeCarry[0] |=> s_q.irqStat[hspc_pkg::EV_CARRY])
        else $error("carry event not recorded");
    AST_READY_AFTER_SETUP: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !penable) |=> pready ##1 !pready || (psel && !penable))
        else $error("apb ready timing wrong");
    COV_IRQ: cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq));
    COV_WRITE: cover property (@(posedge mclk) disable iff (!rst_n) access && pwrite);
endmodule

// file: tb/hspc_pulse_src.sv
// square wave pulse source that stands in for the field inputs
`timescale 1ns/10ps
module hspc_pulse_src (
    input wire logic mclk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [3:0] fire, // start a burst on these inputs
    input wire logic [7:0] half, // cycles high, and again cycles low
    input wire logic [7:0] count, // periods in one burst
    output logic [3:0] pulseOut, // counter inputs
    output logic busy // burst in progress
);
    logic [3:0] mask_q = 4'h0;
    logic [7:0] left_q = 8'h00;
    logic [7:0] tick_q = 8'h00;
    logic level_q = 1'b0;
    logic busy_q = 1'b0;

    // each period starts low, so two bursts never merge into one edge
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            level_q <= 1'b0;
        end
        else if (!busy_q && fire != 4'h0)
        begin
            mask_q <= fire;
            left_q <= count;
            tick_q <= 8'h00;
            busy_q <= 1'b1;
        end
        else if (busy_q && tick_q == half - 8'h01)
        begin
            tick_q <= 8'h00;
            level_q <= !level_q;
            if (level_q && left_q == 8'h01)
                busy_q <= 1'b0;
            if (level_q)
                left_q <= left_q - 8'h01;
        end
        else if (busy_q)
            tick_q <= tick_q + 8'h01;
    end

    // unselected inputs stay low for the whole burst
    assign pulseOut = level_q ? mask_q : 4'h0;
    assign busy = busy_q;
endmodule

// file: tb/tb_high_speed_updown_counter.sv
// testbench: four fast pulse counters driven over apb
`timescale 1ns/10ps
module tb_high_speed_updown_counter;
    localparam logic [31:0] C_EN = 32'h0000_0001 << hspc_pkg::CTRL_ENABLE;
    localparam logic [31:0] C_REL = 32'h0000_0001 << hspc_pkg::CTRL_RELEASE;
    localparam logic [31:0] C_DN = 32'h0000_0001 << hspc_pkg::CTRL_DOWN;
    localparam logic [31:0] C_PRE = 32'h0000_0001 << hspc_pkg::CTRL_PRESET;
    localparam logic [31:0] C_CLR = 32'h0000_0001 << hspc_pkg::CTRL_CLEAR;
    localparam logic [2:0] ACT = hspc_pkg::REG_ACTUAL;
    localparam logic [7:0] STS = hspc_pkg::OFF_IRQ_STATUS;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] fire = 4'h0;
    logic [7:0] burstLen = 8'h00;
    logic [3:0] counterInput, upperFlag, lowerFlag, rangeCarry;
    logic [31:0] prdata, rd, expVal [4];
    logic pready, pslverr, irq, srcBusy, err;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int carryCnt = 0;
    int base;

    hspc_top uut (.mclk(mclk), .rst_n(rst_n), .counterInput(counterInput), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .upperFlag(upperFlag), .lowerFlag(lowerFlag),
        .rangeCarry(rangeCarry), .irq(irq));
    hspc_pulse_src src (.mclk(mclk), .rst_n(rst_n), .fire(fire), .half(8'h02),
        .count(burstLen), .pulseOut(counterInput), .busy(srcBusy));

    always #2 mclk = ~mclk;

    // cycle budget and a running tally of carry pulse cycles
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        carryCnt <= carryCnt + $countones(rangeCarry);
        if (cycles == 20000)
        begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no local cap: only the cycle budget ends a hung wait
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // short pause first: flags trail a threshold write by a cycle
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        repeat (3) @(posedge mclk);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp, what);
    endtask

    task automatic burst(input logic [3:0] m, input logic [7:0] k);
        @(posedge mclk);
        fire <= m;
        burstLen <= k;
        @(posedge mclk);
        fire <= 4'h0;
        do
        begin
            @(posedge mclk);
        end
        while (srcBusy === 1'b1);
        repeat (4) @(posedge mclk);
    endtask

    function automatic logic [7:0] ra(input int ch, input logic [2:0] r);
        return 8'((ch << hspc_pkg::CH_SEL_LSB) | (int'(r) << hspc_pkg::REG_SEL_LSB));
    endfunction

    initial
    begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        // reset state, flags of zero thresholds and a refused address
        for (int r = 0; r < 5; r++)
            rdChk(ra(0, 3'(r)), 32'h0000_0000, "reset value");
        rdChk(ra(0, hspc_pkg::REG_FLAGS), 32'h0000_0007, "reset flags");
        xfer(1'b0, ra(0, 3'h6), 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001, "unmapped error");
        xfer(1'b0, STS, 32'h0000_0000);
        check(rd, 32'h0000_0DB6, "flag rise events");
        rdChk(STS, 32'h0000_0000, "status read clears");
        // odd channels count down; each counts only its own input
        for (int c = 0; c < 4; c++)
        begin
            xfer(1'b1, ra(c, hspc_pkg::REG_UPPER), 32'h7FFF_FFFF);
            xfer(1'b1, ra(c, hspc_pkg::REG_LOWER), 32'h8000_0000);
            xfer(1'b1, ra(c, hspc_pkg::REG_CTRL), (c % 2) ? C_DN : 32'h0000_0000);
            expVal[c] = 32'h0000_0000;
        end
        for (int c = 0; c < 4; c++)
        begin
            burst(4'(1 << c), 8'(3 + c));
            expVal[c] = 32'((c % 2) ? -(3 + c) : 3 + c);
            for (int k = 0; k < 4; k++)
                rdChk(ra(k, ACT), expVal[k], "count per channel");
        end
        check({28'h0, upperFlag | lowerFlag}, 32'h0000_0000, "flags inside range");
        // enable gates only once the release option is on
        xfer(1'b1, ra(0, hspc_pkg::REG_CTRL), C_REL);
        burst(4'h1, 8'h02);
        rdChk(ra(0, ACT), 32'h0000_0003, "disabled holds");
        xfer(1'b1, ra(0, hspc_pkg::REG_CTRL), C_REL | C_EN);
        burst(4'h1, 8'h02);
        rdChk(ra(0, ACT), 32'h0000_0005, "enabled counts");
        // thresholds met exactly
        xfer(1'b1, ra(0, hspc_pkg::REG_UPPER), 32'h0000_0006);
        rdChk(ra(0, hspc_pkg::REG_FLAGS), 32'h0000_0000, "below upper");
        burst(4'h1, 8'h01);
        check({31'h0, upperFlag[0]}, 32'h0000_0001, "at upper");
        xfer(1'b1, ra(0, hspc_pkg::REG_LOWER), 32'h0000_0005);
        xfer(1'b1, ra(0, hspc_pkg::REG_CTRL), C_REL | C_EN | C_DN);
        burst(4'h1, 8'h01);
        rdChk(ra(0, hspc_pkg::REG_FLAGS), 32'h0000_0002, "at lower");
        check({31'h0, lowerFlag[0]}, 32'h0000_0001, "lower port");
        xfer(1'b1, ra(0, hspc_pkg::REG_UPPER), 32'h0000_0005);
        rdChk(ra(0, hspc_pkg::REG_FLAGS), 32'h0000_0003, "threshold moved");
        // preset on the edge only, clear wins over preset and pulses
        xfer(1'b1, ra(1, hspc_pkg::REG_START), 32'hFFFF_FFFB);
        xfer(1'b1, ra(1, hspc_pkg::REG_CTRL), C_PRE);
        rdChk(ra(1, ACT), 32'hFFFF_FFFB, "preset loads");
        burst(4'h2, 8'h01);
        rdChk(ra(1, ACT), 32'hFFFF_FFFC, "held preset no reload");
        xfer(1'b1, ra(1, hspc_pkg::REG_CTRL), C_CLR);
        burst(4'h2, 8'h02);
        rdChk(ra(1, ACT), 32'h0000_0000, "clear holds zero");
        xfer(1'b1, ra(1, hspc_pkg::REG_CTRL), C_CLR | C_PRE);
        rdChk(ra(1, ACT), 32'h0000_0000, "clear beats preset");
        xfer(1'b1, ra(1, hspc_pkg::REG_CTRL), 32'h0000_0000);
        burst(4'h2, 8'h01);
        rdChk(ra(1, ACT), 32'h0000_0001, "counts after clear");
        // top of range: value kept, one carry per edge, irq unmasked
        xfer(1'b1, hspc_pkg::OFF_IRQ_MASK, 32'h0000_0040);
        xfer(1'b0, STS, 32'h0000_0000);
        xfer(1'b1, ra(2, hspc_pkg::REG_START), 32'h7FFF_FFFF);
        xfer(1'b1, ra(2, hspc_pkg::REG_CTRL), C_PRE);
        base = carryCnt;
        burst(4'h4, 8'h02);
        rdChk(ra(2, ACT), 32'h7FFF_FFFF, "no wrap at top");
        check(32'(carryCnt - base), 32'h0000_0002, "carry per edge");
        check({30'h0, irq, upperFlag[2]}, 32'h0000_0003, "irq and upper");
        xfer(1'b0, STS, 32'h0000_0000);
        check(rd & 32'h0000_0040, 32'h0000_0040, "carry event");
        repeat (2) @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0000, "read drops irq");
        // bottom of range counting down, carry event left masked
        xfer(1'b1, ra(3, hspc_pkg::REG_START), 32'h8000_0000);
        xfer(1'b1, ra(3, hspc_pkg::REG_CTRL), C_DN | C_PRE);
        base = carryCnt;
        burst(4'h8, 8'h01);
        rdChk(ra(3, ACT), 32'h8000_0000, "no wrap at bottom");
        check(32'(carryCnt - base), 32'h0000_0001, "single carry");
        check({31'h0, irq}, 32'h0000_0000, "masked carry");
        xfer(1'b0, STS, 32'h0000_0000);
        check(rd & 32'h0000_0200, 32'h0000_0200, "masked event kept");
        results();
    end
endmodule
